/* rtl/srl_link_ctrl.sv */
// Overview of operation
// [R1] Status bit 2 shows input PLL lock
// [R2] Status bit 1 flags no input clock
// [R3] Status bit 0 flags stable input rate
// [R4] Independent mode: status follows selected port
// [R5] Control bit 7: 0 twisted pair, 1 coax
// [R6] Cable bit loads from strap pin b
// [R7] Swap bit writable only with auto-swap disabled
// [R8] Bit 5 resets serial PLL on rate change
// [R9] Bit 4 picks rate detector clock source
// [R10] Align bit: odd primary, even secondary, on DE
// [R11] Three-bit field selects transmit mode
// [R12] Software never writes reserved codes 010, 110
// [R13] Mode field loads 000 or 111 from strap a
// [R14] Independent mode only with video inputs disabled
`timescale 1ns/1ns
`default_nettype none
module srl_link_ctrl (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Per-port input clock status pins
  input  wire logic [1:0]  input_pll_lock,
  input  wire logic [1:0]  no_input_clock,
  input  wire logic [1:0]  input_rate_steady,
  // Link and detector pins
  input  wire logic        swap_detected,
  input  wire logic        dual_partner,
  input  wire logic        rate_change_toggle,
  input  wire logic        strap_pin_a,
  input  wire logic        strap_pin_b,
  // Pixel stream
  input  wire logic        pix_valid,
  input  wire logic        pix_de,
  output logic             pixel_on_secondary,
  // Link settings
  output logic             cable_type_select,
  output logic             link_swap,
  output logic             serial_pll_reset,
  output logic             rate_detect_source,
  output logic [2:0]       transmit_mode_select,
  output logic             port1_disable,
  output logic             independent_mode,
  output logic             splitter_mode,
  // Interrupt
  output logic             irq
);

  srl_pin_if #(.W(srl_pkg::PIN_W)) pins ();

  srl_pin_sync #(.W(srl_pkg::PIN_W)) u_sync (
    .clock (clock),
    .rst   (rst),
    .raw   ({strap_pin_b, strap_pin_a, rate_change_toggle, dual_partner, swap_detected,
             input_rate_steady, no_input_clock, input_pll_lock}),
    .q     (pins.src)
  );

  logic [1:0]  lock_s;
  logic [1:0]  noclk_s;
  logic [1:0]  stable_s;
  assign lock_s   = pins.level[srl_pkg::PIN_LOCK +: 2];
  assign noclk_s  = pins.level[srl_pkg::PIN_NOCLK +: 2];
  assign stable_s = pins.level[srl_pkg::PIN_STABLE +: 2];

  srl_pkg::srl_boot_type boot_r;
  logic [1:0]  settle_r;
  logic [7:0]  ctl1_r;
  logic [7:0]  ctl2_r;
  logic        port_sel_r;
  logic [3:0]  irq_sts_r;
  logic [3:0]  irq_en_r;
  logic [1:0]  lock_q_r;
  logic [1:0]  noclk_q_r;
  logic [1:0]  stable_q_r;
  logic        rate_q_r;
  logic        wr_pend_r;
  logic [7:0]  wr_idx_r;
  logic        de_q_r;
  logic        next_sec_r;

  logic        accept;
  logic [7:0]  wdat;
  logic [2:0]  mode;
  logic        sel;
  logic [7:0]  status_byte;
  logic        rate_ev;
  logic [3:0]  irq_ev;
  logic        wr_ctl1;
  logic        dual_active;
  logic        line_start;
  logic        pix_link;

  assign wdat    = hwdata[7:0];
  assign mode    = ctl1_r[srl_pkg::CTL1_MODE_LSB +: 3];
  assign accept  = hsel & htrans[1] & hready & hreadyout;
  assign wr_ctl1 = wr_pend_r & (wr_idx_r == srl_pkg::IDX_CTL1);

  // Port select only matters in independent mode
  assign sel = (mode == srl_pkg::MODE_INDEP) ? port_sel_r : 1'b0; // R4
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[srl_pkg::STS_LOCK]   = lock_s[sel];   // R1
    status_byte[srl_pkg::STS_NOCLK]  = noclk_s[sel];  // R2
    status_byte[srl_pkg::STS_STABLE] = stable_s[sel]; // R3
  end

  function automatic logic [7:0] read_mux(input logic [7:0] idx);
    unique case (idx)
      srl_pkg::IDX_STATUS:   read_mux = status_byte;
      srl_pkg::IDX_CTL1:     read_mux = ctl1_r;
      srl_pkg::IDX_CTL2:     read_mux = ctl2_r;
      srl_pkg::IDX_IRQ_STS:  read_mux = {4'h0, irq_sts_r};
      srl_pkg::IDX_IRQ_EN:   read_mux = {4'h0, irq_en_r};
      srl_pkg::IDX_PORT_SEL: read_mux = {7'h00, port_sel_r};
      default:               read_mux = 8'h00;
    endcase
  endfunction

  // Straps are sampled only after the synchroniser has filled
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      boot_r   <= srl_pkg::BOOT_WAIT;
      settle_r <= 2'h0;
    end
    else
    begin
      unique case (boot_r)
        srl_pkg::BOOT_WAIT:
        begin
          settle_r <= settle_r + 2'h1;
          if (settle_r == srl_pkg::STRAP_SETTLE)
            boot_r <= srl_pkg::BOOT_LOAD;
        end
        srl_pkg::BOOT_LOAD: boot_r <= srl_pkg::BOOT_RUN;
        srl_pkg::BOOT_RUN:  boot_r <= srl_pkg::BOOT_RUN;
        default:            boot_r <= srl_pkg::BOOT_WAIT;
      endcase
    end
  end

  // Bus slave: read data registered at the address phase
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      hreadyout <= 1'b0;
      hresp     <= srl_pkg::HRESP_OKAY;
      hrdata    <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
    end
    else
    begin
      hreadyout <= (boot_r != srl_pkg::BOOT_WAIT);
      hresp     <= srl_pkg::HRESP_OKAY;
      wr_pend_r <= accept & hwrite;
      if (accept)
        wr_idx_r <= srl_pkg::srl_index(haddr);
      if (accept & ~hwrite)
        hrdata <= {24'h00_0000, read_mux(srl_pkg::srl_index(haddr))};
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctl1_r <= 8'h00;
    end
    else if (boot_r == srl_pkg::BOOT_LOAD)
    begin
      ctl1_r[srl_pkg::CTL1_CABLE] <= pins.level[srl_pkg::PIN_STRAPB]; // R6
      ctl1_r[srl_pkg::CTL1_MODE_LSB +: 3] <= pins.level[srl_pkg::PIN_STRAPA]
        ? srl_pkg::MODE_SPLIT : srl_pkg::MODE_AUTO; // R13
    end
    else
    begin
      if (wr_ctl1)
      begin
        ctl1_r[srl_pkg::CTL1_CABLE]   <= wdat[srl_pkg::CTL1_CABLE]; // R5
        ctl1_r[srl_pkg::CTL1_PLL_RST] <= wdat[srl_pkg::CTL1_PLL_RST];
        ctl1_r[srl_pkg::CTL1_SRC]     <= wdat[srl_pkg::CTL1_SRC];
        ctl1_r[srl_pkg::CTL1_ALIGN]   <= wdat[srl_pkg::CTL1_ALIGN];
        ctl1_r[srl_pkg::CTL1_MODE_LSB +: 3] <= wdat[srl_pkg::CTL1_MODE_LSB +: 3]; // R11
      end
      // Auto correction owns the swap bit unless disabled
      if (!ctl2_r[srl_pkg::CTL2_NOSWAP])
        ctl1_r[srl_pkg::CTL1_SWAP] <= pins.level[srl_pkg::PIN_SWAP]; // R7
      else if (wr_ctl1)
        ctl1_r[srl_pkg::CTL1_SWAP] <= wdat[srl_pkg::CTL1_SWAP]; // R7
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctl2_r     <= srl_pkg::CTL2_RESET;
      port_sel_r <= 1'b0;
      irq_en_r   <= 4'h0;
    end
    else if (wr_pend_r)
    begin
      if (wr_idx_r == srl_pkg::IDX_CTL2)
        ctl2_r <= wdat;
      if (wr_idx_r == srl_pkg::IDX_PORT_SEL)
        port_sel_r <= wdat[0];
      if (wr_idx_r == srl_pkg::IDX_IRQ_EN)
        irq_en_r <= wdat[3:0];
    end
  end

  // Events and sticky status; a new event beats a clear
  assign rate_ev = pins.level[srl_pkg::PIN_RATE] ^ rate_q_r;
  always_comb
  begin
    irq_ev = 4'h0;
    irq_ev[srl_pkg::IRQ_LOCK]   = |(lock_s ^ lock_q_r);
    irq_ev[srl_pkg::IRQ_NOCLK]  = |(noclk_s & ~noclk_q_r);
    irq_ev[srl_pkg::IRQ_STABLE] = |(stable_s & ~stable_q_r);
    irq_ev[srl_pkg::IRQ_RATE]   = rate_ev;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      lock_q_r   <= 2'h0;
      noclk_q_r  <= 2'h0;
      stable_q_r <= 2'h0;
      rate_q_r   <= 1'b0;
      irq_sts_r  <= 4'h0;
      irq        <= 1'b0;
    end
    else
    begin
      lock_q_r   <= lock_s;
      noclk_q_r  <= noclk_s;
      stable_q_r <= stable_s;
      rate_q_r   <= pins.level[srl_pkg::PIN_RATE];
      if (wr_pend_r && wr_idx_r == srl_pkg::IDX_IRQ_CLR)
        irq_sts_r <= (irq_sts_r & ~wdat[3:0]) | irq_ev;
      else
        irq_sts_r <= irq_sts_r | irq_ev;
      irq <= |(irq_sts_r & irq_en_r);
    end
  end

  // Link settings driven out of flops
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      serial_pll_reset     <= 1'b0;
      cable_type_select    <= 1'b0;
      link_swap            <= 1'b0;
      rate_detect_source   <= 1'b0;
      transmit_mode_select <= 3'h0;
      port1_disable        <= 1'b0;
      independent_mode     <= 1'b0;
      splitter_mode        <= 1'b0;
    end
    else
    begin
      serial_pll_reset     <= rate_ev & ctl1_r[srl_pkg::CTL1_PLL_RST]; // R8
      cable_type_select    <= ctl1_r[srl_pkg::CTL1_CABLE]; // R5
      link_swap            <= ctl1_r[srl_pkg::CTL1_SWAP];
      rate_detect_source   <= ctl1_r[srl_pkg::CTL1_SRC]; // R9
      transmit_mode_select <= mode; // R11
      port1_disable        <= (mode == srl_pkg::MODE_SINGLE); // R11
      independent_mode     <= (mode == srl_pkg::MODE_INDEP); // R11
      splitter_mode        <= (mode == srl_pkg::MODE_SPLIT); // R11
    end
  end

  // Reserved codes are not decoded: they act as no forced mode
  assign dual_active = (mode == srl_pkg::MODE_DUAL) ||
                       (mode == srl_pkg::MODE_AUTO && pins.level[srl_pkg::PIN_DUAL]); // R12
  assign line_start  = pix_valid & pix_de & ~de_q_r;
  assign pix_link    = (ctl1_r[srl_pkg::CTL1_ALIGN] & line_start) ? 1'b0 : next_sec_r; // R10

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      de_q_r             <= 1'b0;
      next_sec_r         <= 1'b0;
      pixel_on_secondary <= 1'b0;
    end
    else
    begin
      if (pix_valid)
        de_q_r <= pix_de;
      if (!dual_active)
      begin
        next_sec_r         <= 1'b0;
        pixel_on_secondary <= 1'b0;
      end
      else if (pix_valid & pix_de)
      begin
        pixel_on_secondary <= pix_link; // R10
        next_sec_r         <= ~pix_link;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_rd_status;
    accept && !hwrite && srl_pkg::srl_index(haddr) == srl_pkg::IDX_STATUS;
  endsequence

  property p_lock;
    s_rd_status |=> hrdata[srl_pkg::STS_LOCK] == $past(lock_s[sel]);
  endproperty
  a_lock: assert property (p_lock) else $error("lock bit wrong"); // R1

  property p_noclk;
    s_rd_status |=> hrdata[srl_pkg::STS_NOCLK] == $past(noclk_s[sel]);
  endproperty
  a_noclk: assert property (p_noclk) else $error("no clock bit wrong"); // R2

  property p_stable;
    s_rd_status |=> hrdata[srl_pkg::STS_STABLE] == $past(stable_s[sel]);
  endproperty
  a_stable: assert property (p_stable) else $error("stable bit wrong"); // R3

  property p_port0;
    s_rd_status ##0 (mode != srl_pkg::MODE_INDEP) |=> hrdata[2:0] ==
      {$past(lock_s[0]), $past(noclk_s[0]), $past(stable_s[0])};
  endproperty
  a_port0: assert property (p_port0) else $error("status not port 0"); // R4

  property p_cable;
    wr_ctl1 && boot_r == srl_pkg::BOOT_RUN |=> ##1 cable_type_select == $past(wdat[7], 2);
  endproperty
  a_cable: assert property (p_cable) else $error("cable bit not applied"); // R5

  property p_strap;
    boot_r == srl_pkg::BOOT_LOAD |=> ctl1_r[srl_pkg::CTL1_CABLE] == $past(pins.level[10]) &&
      (mode == srl_pkg::MODE_AUTO || mode == srl_pkg::MODE_SPLIT);
  endproperty
  a_strap: assert property (p_strap) else $error("strap load wrong"); // R6

  property p_swap;
    !ctl2_r[srl_pkg::CTL2_NOSWAP] && boot_r == srl_pkg::BOOT_RUN &&
      $stable(pins.level[srl_pkg::PIN_SWAP]) [*2] |=> link_swap == $past(pins.level[6], 2);
  endproperty
  a_swap: assert property (p_swap) else $error("auto swap not followed"); // R7

  property p_pll;
    rate_ev |=> serial_pll_reset == $past(ctl1_r[srl_pkg::CTL1_PLL_RST]);
  endproperty
  a_pll: assert property (p_pll) else $error("pll reset wrong"); // R8

  property p_src;
    ##1 rate_detect_source == $past(ctl1_r[srl_pkg::CTL1_SRC]);
  endproperty
  a_src: assert property (p_src) else $error("source bit wrong"); // R9

  property p_align;
    dual_active && line_start && ctl1_r[srl_pkg::CTL1_ALIGN] |=> !pixel_on_secondary;
  endproperty
  a_align: assert property (p_align) else $error("line start not primary"); // R10

  property p_single;
    ##1 port1_disable == ($past(mode) == srl_pkg::MODE_SINGLE);
  endproperty
  a_single: assert property (p_single) else $error("port 1 disable wrong"); // R11

endmodule
`default_nettype wire

/* rtl/srl_pin_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface srl_pin_if #(parameter int W = 1);
  logic [W-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface
`default_nettype wire

/* rtl/srl_pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module srl_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Raw pins and filtered levels
  input  wire logic [W-1:0] raw,
  srl_pin_if.src            q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A bit moves only once the last two stages agree
  always_ff @(posedge clock)
  begin
    if (rst)
      q.level <= '0;
    else
      q.level <= (s2_r & s3_r) | (q.level & (s2_r | s3_r));
  end

endmodule
`default_nettype wire

/* rtl/srl_pkg.sv */
`default_nettype none
package srl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS   = 8'h5a;
  localparam logic [7:0] IDX_CTL1     = 8'h5b;
  localparam logic [7:0] IDX_CTL2     = 8'h5c;
  localparam logic [7:0] IDX_IRQ_STS  = 8'h70;
  localparam logic [7:0] IDX_IRQ_EN   = 8'h71;
  localparam logic [7:0] IDX_IRQ_CLR  = 8'h72;
  localparam logic [7:0] IDX_PORT_SEL = 8'h73;

  // Control one fields
  localparam int CTL1_CABLE    = 7;
  localparam int CTL1_SWAP     = 6;
  localparam int CTL1_PLL_RST  = 5;
  localparam int CTL1_SRC      = 4;
  localparam int CTL1_ALIGN    = 3;
  localparam int CTL1_MODE_LSB = 0;

  // Control two fields
  localparam logic [7:0] CTL2_RESET  = 8'h07;
  localparam int         CTL2_NOSWAP = 7;

  // Status fields
  localparam int STS_LOCK   = 2;
  localparam int STS_NOCLK  = 1;
  localparam int STS_STABLE = 0;

  // Interrupt bits
  localparam int IRQ_LOCK   = 0;
  localparam int IRQ_NOCLK  = 1;
  localparam int IRQ_STABLE = 2;
  localparam int IRQ_RATE   = 3;
  localparam int IRQ_W      = 4;

  // Synchronised pin vector layout
  localparam int PIN_LOCK   = 0;
  localparam int PIN_NOCLK  = 2;
  localparam int PIN_STABLE = 4;
  localparam int PIN_SWAP   = 6;
  localparam int PIN_DUAL   = 7;
  localparam int PIN_RATE   = 8;
  localparam int PIN_STRAPA = 9;
  localparam int PIN_STRAPB = 10;
  localparam int PIN_W      = 11;

  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic       HRESP_OKAY   = 1'b0;

  typedef enum logic [2:0] {
    MODE_AUTO     = 3'h0,
    MODE_SINGLE   = 3'h1,
    MODE_RSV_A    = 3'h2,
    MODE_DUAL     = 3'h3,
    MODE_AUTO_ND  = 3'h4,
    MODE_INDEP    = 3'h5,
    MODE_RSV_B    = 3'h6,
    MODE_SPLIT    = 3'h7
  } srl_mode_type;

  typedef enum logic [2:0] {
    BOOT_WAIT = 3'b001,
    BOOT_LOAD = 3'b010,
    BOOT_RUN  = 3'b100
  } srl_boot_type;

  function automatic logic [7:0] srl_index(input logic [11:0] addr);
    return addr[9:2];
  endfunction

endpackage
`default_nettype wire

/* tb/serializer_link_mode_ctrl_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module serializer_link_mode_ctrl_tb;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout, hresp, pixel_on_secondary, cable_type_select, link_swap;
  logic        serial_pll_reset, rate_detect_source, port1_disable, independent_mode;
  logic        splitter_mode, irq, swap_detected, dual_partner, rate_change_toggle;
  logic [31:0] hrdata;
  logic [2:0]  transmit_mode_select;
  logic [1:0]  input_pll_lock, no_input_clock, input_rate_steady;
  logic        pix_valid = 1'b0;
  logic        pix_de = 1'b0;
  logic [5:0]  stat_cmd = 6'h19;
  logic        swap_cmd = 1'b0;
  logic        rate_cmd = 1'b0;
  logic        dual_cmd = 1'b0;
  logic        strap_pin_a = 1'b1;
  logic        strap_pin_b = 1'b1;
  logic [2:0]  codes [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h7};
  int          failures = 0;
  int          check_count = 0;
  int          n;

  always #5 clock = ~clock;

  srl_link_ctrl u_srl_link_ctrl (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .input_pll_lock(input_pll_lock),
    .no_input_clock(no_input_clock), .input_rate_steady(input_rate_steady),
    .swap_detected(swap_detected), .dual_partner(dual_partner),
    .rate_change_toggle(rate_change_toggle), .strap_pin_a(strap_pin_a),
    .strap_pin_b(strap_pin_b),
    .pix_valid(pix_valid), .pix_de(pix_de), .pixel_on_secondary(pixel_on_secondary),
    .cable_type_select(cable_type_select), .link_swap(link_swap),
    .serial_pll_reset(serial_pll_reset), .rate_detect_source(rate_detect_source),
    .transmit_mode_select(transmit_mode_select), .port1_disable(port1_disable),
    .independent_mode(independent_mode), .splitter_mode(splitter_mode), .irq(irq));

  srl_far_model u_srl_far_model (.clock(clock), .stat_cmd(stat_cmd), .swap_cmd(swap_cmd),
    .dual_cmd(dual_cmd), .rate_cmd(rate_cmd), .input_pll_lock(input_pll_lock),
    .no_input_clock(no_input_clock), .input_rate_steady(input_rate_steady),
    .swap_detected(swap_detected), .dual_partner(dual_partner),
    .rate_change_toggle(rate_change_toggle));

  task stop_test;
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task wt(input int c);
    repeat (c) @(posedge clock);
  endtask

  // Bounded wait for hready sampled high at a rising edge
  task wait_rdy;
    int k;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1)
    begin
      failures++;
      stop_test();
    end
  endtask

  task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
            output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {2'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] t;
    xfer(1'b1, idx, d, t);
  endtask

  task rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] t;
    xfer(1'b0, idx, 8'h00, t);
    check(t, {24'h0, exp});
  endtask

  // One line of n pixels; expected link of the first given
  task line(input int cnt, input logic first);
    logic e;
    e = first;
    repeat (cnt)
    begin
      pix_valid <= 1'b1;
      pix_de    <= 1'b1;
      @(posedge clock);
      pix_valid <= 1'b0;
      wt(1);
      check({31'h0, pixel_on_secondary}, {31'h0, e});
      e = ~e;
    end
    // Line end is only seen on a qualified blanking pixel
    pix_valid <= 1'b1;
    pix_de    <= 1'b0;
    @(posedge clock);
    pix_valid <= 1'b0;
    @(posedge clock);
  endtask

  // Raise one rate change event and count reset pulses after it
  task rate_evt(output int cnt);
    cnt = 0;
    rate_cmd <= 1'b1;
    @(posedge clock);
    rate_cmd <= 1'b0;
    repeat (12)
    begin
      @(posedge clock);
      if (serial_pll_reset === 1'b1)
        cnt++;
    end
  endtask

  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rdc(srl_pkg::IDX_CTL1, 8'h87);
    rdc(srl_pkg::IDX_CTL2, 8'h07);
    rdc(8'h10, 8'h00);
    check({29'h0, cable_type_select, splitter_mode, rate_detect_source}, 32'h6);
    rdc(srl_pkg::IDX_STATUS, 8'h05);
    // Video inputs are taken as held disabled before independent mode
    wr(srl_pkg::IDX_CTL1, 8'h05);
    wr(srl_pkg::IDX_PORT_SEL, 8'h01);
    rdc(srl_pkg::IDX_STATUS, 8'h02);
    // Reserved codes are never written
    foreach (codes[i])
    begin
      wr(srl_pkg::IDX_CTL1, {5'h02, codes[i]});
      wt(2);
      check(32'({rate_detect_source, port1_disable, independent_mode, splitter_mode,
        transmit_mode_select}), 32'({1'b1, codes[i] == 3'h1, codes[i] == 3'h5,
        codes[i] == 3'h7, codes[i]}));
      rdc(srl_pkg::IDX_CTL1, {5'h02, codes[i]});
    end
    swap_cmd <= 1'b1;
    wt(8);
    wr(srl_pkg::IDX_CTL1, 8'h17);
    wt(2);
    rdc(srl_pkg::IDX_CTL1, 8'h57);
    check({31'h0, link_swap}, 32'h1);
    wr(srl_pkg::IDX_CTL2, 8'h87);
    wr(srl_pkg::IDX_CTL1, 8'h17);
    wt(2);
    check({31'h0, link_swap}, 32'h0);
    wr(srl_pkg::IDX_CTL1, 8'h0b);
    wt(2);
    line(3, 1'b0);
    line(1, 1'b0);
    wr(srl_pkg::IDX_CTL1, 8'h03);
    wt(2);
    line(1, 1'b1);
    wr(srl_pkg::IDX_IRQ_CLR, 8'h0f);
    wr(srl_pkg::IDX_IRQ_EN, 8'h08);
    wr(srl_pkg::IDX_CTL1, 8'h23);
    wt(2);
    rate_evt(n);
    check(32'(n), 32'h1);
    check({31'h0, irq}, 32'h1);
    rdc(srl_pkg::IDX_IRQ_STS, 8'h08);
    wr(srl_pkg::IDX_IRQ_EN, 8'h00);
    wt(2);
    check({31'h0, irq}, 32'h0);
    wr(srl_pkg::IDX_IRQ_CLR, 8'h08);
    rdc(srl_pkg::IDX_IRQ_STS, 8'h00);
    wr(srl_pkg::IDX_CTL1, 8'h03);
    wt(2);
    rate_evt(n);
    check(32'(n), 32'h0);
    wr(srl_pkg::IDX_IRQ_CLR, 8'h0f);
    stat_cmd <= 6'h26;
    wt(8);
    rdc(srl_pkg::IDX_STATUS, 8'h02);
    rdc(srl_pkg::IDX_IRQ_STS, 8'h07);
    // Auto mode goes dual only with a capable partner
    dual_cmd <= 1'b1;
    wr(srl_pkg::IDX_CTL1, 8'h08);
    wt(8);
    line(2, 1'b0);
    // Second reset with mixed strap levels
    rst         <= 1'b1;
    strap_pin_a <= 1'b0;
    swap_cmd    <= 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rdc(srl_pkg::IDX_CTL1, 8'h80);
    rdc(srl_pkg::IDX_CTL2, 8'h07);
    check({29'h0, cable_type_select, splitter_mode, rate_detect_source}, 32'h4);
    stop_test();
  end
endmodule
`default_nettype wire

/* tb/srl_far_model.sv */
`timescale 1ns/1ns
`default_nettype none
module srl_far_model (
  // Clock
  input  wire logic       clock,
  // Bench commands
  input  wire logic [5:0] stat_cmd,
  input  wire logic       swap_cmd,
  input  wire logic       dual_cmd,
  input  wire logic       rate_cmd,
  // Pins toward the block
  output logic [1:0]      input_pll_lock,
  output logic [1:0]      no_input_clock,
  output logic [1:0]      input_rate_steady,
  output logic            swap_detected,
  output logic            dual_partner,
  output logic            rate_change_toggle
);
  initial rate_change_toggle = 1'b0;
  // Levels change only on an edge, like the far side's own flops
  always @(posedge clock)
  begin
    input_pll_lock     <= stat_cmd[1:0];
    no_input_clock     <= stat_cmd[3:2];
    input_rate_steady  <= stat_cmd[5:4];
    swap_detected      <= swap_cmd;
    dual_partner       <= dual_cmd;
    rate_change_toggle <= rate_change_toggle ^ rate_cmd;
  end
endmodule
`default_nettype wire
